// ### hw/csfb_core.sv
/*
 * Core special-function logic: bank selector, working result register,
 * program counter low byte, table read, status flags and event interrupt.
 * Assumes control inputs come from logic on clk_sys and a synchronous ROM.
 */
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module csfb_core
    import csfb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire csfb_instr_t instr,
    input wire logic instrValid,
    output logic instrReady,
    output logic memBank,
    output logic [7:0] memWrData,
    output logic [6:0] memWrAddr,
    output logic memWrValid,
    output logic [PC_W-1:0] pcOut,
    output logic dummyCycle,
    input wire logic tblReadReq,
    output logic [15:0] progAddr,
    input wire logic [15:0] progData,
    output logic [7:0] tblLowData,
    output logic tblLowValid,
    input wire logic callReq,
    output logic [PC_W-1:0] pushData,
    output logic pushValid,
    input wire logic haltExec,
    input wire logic wdtRefreshExec,
    input wire logic wdtTimeout,
    input wire logic softReset,
    input wire logic softResetWdtIdle,
    output logic irq
);

logic bank_r;
logic [7:0] acc_r;
logic [PC_W-1:0] pc_r;
logic dummy_r;
logic [7:0] table_pointer_low_r;
logic [7:0] table_pointer_high_r;
logic [7:0] table_result_high_r;
csfb_flags_t flags_r;
logic timeout_r;
logic halt_r;
logic [EVT_W-1:0] evtStat_r;
logic [EVT_W-1:0] evtEn_r;
logic [7:0] rdData_r;
csfb_tbl_state_t tblState_r;
logic [7:0] memWrData_r;
logic [6:0] memWrAddr_r;
logic memWrValid_r;
logic [7:0] tblLow_r;
logic tblLowValid_r;
logic [PC_W-1:0] push_r;
logic pushValid_r;
logic [7:0] aluResult;
csfb_flags_t aluFlags;
csfb_flags_t aluAffect;
logic instrTake;
logic busWr;
logic jumpInstr;
logic jumpBus;
logic [EVT_W-1:0] evtSet;
logic [7:0] statusView;

// ************************************
// Issue control
// ************************************
assign instrReady = ~dummy_r & (tblState_r == TBL_IDLE);
assign instrTake = instrValid & instrReady;
assign busWr = regWr;
assign jumpInstr = instrTake & instr.toMem & (instr.memAddr == OFF_PCL);
assign jumpBus = busWr & (regAddr == OFF_PCL);

csfb_alu u_alu (
    .op(instr.op),
    .accIn(acc_r),
    .operand(instr.operand),
    .carryIn(flags_r.unsignedOut),
    .result(aluResult),
    .flags(aluFlags),
    .affect(aluAffect)
);

// ************************************
// Bank selector
// ************************************
always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        bank_r <= BANK_RESET;
    end else if (softReset) begin
        if (!softResetWdtIdle) begin
            bank_r <= BANK_RESET;
        end
    end else if (busWr && regAddr == OFF_BANK) begin
        bank_r <= regWrData[BANK_SEL_BIT];
    end
end

assign memBank = instr.indirect ? bank_r : 1'b0;

// ************************************
// Working result register
// ************************************
always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        acc_r <= BYTE_ZERO;
    end else if (instrTake && !instr.toMem && instr.op != OP_NONE) begin
        acc_r <= aluResult;
    end else if (busWr && regAddr == OFF_ACC) begin
        acc_r <= regWrData;
    end
end

// Memory write-back only from the ALU, never memory to memory
always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        memWrData_r <= BYTE_ZERO;
        memWrAddr_r <= '0;
        memWrValid_r <= 1'b0;
    end else begin
        memWrValid_r <= instrTake & instr.toMem & ~jumpInstr;
        if (instrTake && instr.toMem) begin
            memWrData_r <= aluResult;
            memWrAddr_r <= instr.memAddr;
        end
    end
end

assign memWrData = memWrData_r;
assign memWrAddr = memWrAddr_r;
assign memWrValid = memWrValid_r;

// ************************************
// Program counter and dummy cycle
// ************************************
always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        pc_r <= PC_RESET;
    end else if (jumpInstr) begin
        pc_r <= {pc_r[PC_W-1:8], aluResult};
    end else if (jumpBus) begin
        pc_r <= {pc_r[PC_W-1:8], regWrData};
    end else if (instrTake) begin
        pc_r <= pc_r + PC_STEP;
    end
end

always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        dummy_r <= 1'b0;
    end else begin
        dummy_r <= jumpInstr | jumpBus;
    end
end

assign pcOut = pc_r;
assign dummyCycle = dummy_r;

// ************************************
// Call push: return address only
// ************************************
always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        push_r <= PC_RESET;
        pushValid_r <= 1'b0;
    end else begin
        pushValid_r <= callReq;
        if (callReq) begin
            push_r <= pc_r;
        end
    end
end

assign pushData = push_r;
assign pushValid = pushValid_r;

// ************************************
// Table read
// ************************************
always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        table_pointer_low_r <= BYTE_ZERO;
        table_pointer_high_r <= BYTE_ZERO;
    end else if (busWr && regAddr == OFF_TABLE_POINTER_LOW) begin
        table_pointer_low_r <= regWrData;
    end else if (busWr && regAddr == OFF_TABLE_POINTER_HIGH) begin
        table_pointer_high_r <= regWrData;
    end
end

always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        tblState_r <= TBL_IDLE;
        table_result_high_r <= BYTE_ZERO;
        tblLow_r <= BYTE_ZERO;
        tblLowValid_r <= 1'b0;
    end else begin
        tblLowValid_r <= 1'b0;
        unique case (tblState_r)
            TBL_IDLE: begin
                if (tblReadReq && !dummy_r) begin
                    tblState_r <= TBL_FETCH;
                end
            end
            TBL_FETCH: begin
                table_result_high_r <= progData[15:8];
                tblLow_r <= progData[7:0];
                tblLowValid_r <= 1'b1;
                tblState_r <= TBL_IDLE;
            end
            default: tblState_r <= TBL_IDLE;
        endcase
    end
end

assign progAddr = {table_pointer_high_r, table_pointer_low_r};
assign tblLowData = tblLow_r;
assign tblLowValid = tblLowValid_r;

// ************************************
// Arithmetic flags
// ************************************
always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        flags_r <= '0;
    end else if (busWr && regAddr == OFF_STATUS) begin
        flags_r <= regWrData[3:0];
    end else if (instrTake) begin
        if (aluAffect.unsignedOut) begin
            flags_r.unsignedOut <= aluFlags.unsignedOut;
        end
        if (aluAffect.halfNibble) begin
            flags_r.halfNibble <= aluFlags.halfNibble;
        end
        if (aluAffect.nullResult) begin
            flags_r.nullResult <= aluFlags.nullResult;
        end
        if (aluAffect.signedWrap) begin
            flags_r.signedWrap <= aluFlags.signedWrap;
        end
    end
end

// ************************************
// System flags
// ************************************
always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        halt_r <= 1'b0;
    end else if (haltExec) begin
        halt_r <= 1'b1;
    end else if (wdtRefreshExec) begin
        halt_r <= 1'b0;
    end
end

always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        timeout_r <= 1'b0;
    end else if (wdtTimeout) begin
        timeout_r <= 1'b1;
    end else if (wdtRefreshExec || haltExec) begin
        timeout_r <= 1'b0;
    end
end

assign statusView = {2'b00, timeout_r, halt_r, flags_r};

// ************************************
// Event interrupt
// ************************************
assign evtSet = {instrTake & aluAffect.signedWrap & aluFlags.signedWrap,
                 tblLowValid_r, haltExec, wdtTimeout};

always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        evtStat_r <= '0;
    end else begin
        if (busWr && regAddr == OFF_EVT_CLR) begin
            evtStat_r <= (evtStat_r & ~regWrData[EVT_W-1:0]) | evtSet;
        end else begin
            evtStat_r <= evtStat_r | evtSet;
        end
    end
end

always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        evtEn_r <= EVT_EN_RESET;
    end else if (busWr && regAddr == OFF_EVT_EN) begin
        evtEn_r <= regWrData[EVT_W-1:0];
    end
end

assign irq = |(evtStat_r & evtEn_r);

// ************************************
// Register read port
// ************************************
always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        rdData_r <= BYTE_ZERO;
    end else if (regRd) begin
        unique case (regAddr)
            OFF_BANK: rdData_r <= {7'h00, bank_r};
            OFF_ACC: rdData_r <= acc_r;
            OFF_PCL: rdData_r <= pc_r[7:0];
            OFF_TABLE_POINTER_LOW: rdData_r <= table_pointer_low_r;
            OFF_TABLE_POINTER_HIGH: rdData_r <= table_pointer_high_r;
            OFF_TABLE_RESULT_HIGH: rdData_r <= table_result_high_r;
            OFF_STATUS: rdData_r <= statusView;
            OFF_EVT_STAT: rdData_r <= {4'h0, evtStat_r};
            OFF_EVT_EN: rdData_r <= {4'h0, evtEn_r};
            default: rdData_r <= BYTE_ZERO;
        endcase
    end else begin
        rdData_r <= BYTE_ZERO;
    end
end

assign regRdData = rdData_r;

endmodule : csfb_core

// ### hw/csfb_pkg.sv
/*
 * Constants, field layouts and carrier types for the core flag and bank logic.
 * Assumes a single system clock and an 8-bit special-function register space.
 */
package csfb_pkg;

// ************************************
// Widths and register offsets
// ************************************
localparam int DATA_W = 8;
localparam int ADDR_W = 7;
localparam int PC_W = 11;
localparam int EVT_W = 4;
localparam logic [6:0] OFF_BANK = 7'h04;
localparam logic [6:0] OFF_ACC = 7'h05;
localparam logic [6:0] OFF_PCL = 7'h06;
localparam logic [6:0] OFF_TABLE_POINTER_LOW = 7'h07;
localparam logic [6:0] OFF_TABLE_RESULT_HIGH = 7'h08;
localparam logic [6:0] OFF_TABLE_POINTER_HIGH = 7'h09;
localparam logic [6:0] OFF_STATUS = 7'h0A;
localparam logic [6:0] OFF_EVT_STAT = 7'h70;
localparam logic [6:0] OFF_EVT_CLR = 7'h71;
localparam logic [6:0] OFF_EVT_EN = 7'h72;

// ************************************
// Field positions and reset values
// ************************************
localparam int BANK_SEL_BIT = 0;
localparam int ST_TIMEOUT_BIT = 5;
localparam int ST_HALT_BIT = 4;
localparam int EVT_TIMEOUT = 0;
localparam int EVT_HALT = 1;
localparam int EVT_TABLE = 2;
localparam int EVT_WRAP = 3;
localparam logic BANK_RESET = 1'b0;
localparam logic [7:0] BYTE_ZERO = 8'h00;
localparam logic [3:0] EVT_EN_RESET = 4'h0;
localparam logic [10:0] PC_RESET = 11'h000;
localparam logic [10:0] PC_STEP = 11'h001;

// ************************************
// Types
// ************************************
typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_MOVA = 4'h1, OP_ADD = 4'h2, OP_ADC = 4'h3,
    OP_SUB = 4'h4, OP_SBC = 4'h5, OP_AND = 4'h6, OP_OR = 4'h7,
    OP_XOR = 4'h8, OP_CPL = 4'h9, OP_INC = 4'hA, OP_DEC = 4'hB,
    OP_RLC = 4'hC, OP_RRC = 4'hD
} csfb_op_t;

typedef struct packed {
    logic signedWrap;
    logic nullResult;
    logic halfNibble;
    logic unsignedOut;
} csfb_flags_t;

typedef struct packed {
    csfb_op_t op;
    logic [7:0] operand;
    logic toMem;
    logic indirect;
    logic [6:0] memAddr;
} csfb_instr_t;

typedef enum logic [1:0] {
    TBL_IDLE = 2'b01,
    TBL_FETCH = 2'b10
} csfb_tbl_state_t;

endpackage : csfb_pkg

// ### hw/csfb_alu.sv
/*
 * Combinational ALU: result, new flags and the mask of flags each op touches.
 * Assumes the caller registers the result and applies the mask.
 */
`timescale 1ns/10ps
module csfb_alu
    import csfb_pkg::*;
(
    input wire csfb_op_t op,
    input wire logic [7:0] accIn,
    input wire logic [7:0] operand,
    input wire logic carryIn,
    output logic [7:0] result,
    output csfb_flags_t flags,
    output csfb_flags_t affect
);

logic [7:0] addB;
logic addCin;
logic [4:0] lowSum;
logic [7:0] loSevenSum;
logic [8:0] fullSum;

// ************************************
// Shared adder
// ************************************
always_comb begin
    addB = operand;
    addCin = 1'b0;
    unique case (op)
        OP_ADC: addCin = carryIn;
        OP_SUB: begin
            addB = ~operand;
            addCin = 1'b1;
        end
        OP_SBC: begin
            addB = ~operand;
            addCin = carryIn;
        end
        OP_INC: begin
            addB = 8'h01;
        end
        OP_DEC: begin
            addB = 8'hFF;
        end
        default: addB = operand;
    endcase
    lowSum = 5'(accIn[3:0]) + 5'(addB[3:0]) + 5'(addCin);
    loSevenSum = 8'(accIn[6:0]) + 8'(addB[6:0]) + 8'(addCin);
    fullSum = 9'(accIn) + 9'(addB) + 9'(addCin);
end

// ************************************
// Result and flags
// ************************************
always_comb begin
    result = fullSum[7:0];
    affect = '0;
    unique case (op)
        OP_NONE: result = accIn;
        OP_MOVA: result = operand;
        OP_ADD, OP_ADC, OP_SUB, OP_SBC: affect = 4'hF;
        OP_AND: result = accIn & operand;
        OP_OR: result = accIn | operand;
        OP_XOR: result = accIn ^ operand;
        OP_CPL: result = ~operand;
        OP_RLC: result = {operand[6:0], carryIn};
        OP_RRC: result = {carryIn, operand[7:1]};
        default: result = fullSum[7:0];
    endcase
    if (op inside {OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC}) begin
        affect.nullResult = 1'b1;
    end
    if (op inside {OP_RLC, OP_RRC}) begin
        affect.unsignedOut = 1'b1;
    end
    flags.unsignedOut = fullSum[8];
    if (op == OP_RLC) begin
        flags.unsignedOut = operand[7];
    end else if (op == OP_RRC) begin
        flags.unsignedOut = operand[0];
    end
    flags.halfNibble = lowSum[4];
    flags.nullResult = (result == BYTE_ZERO);
    flags.signedWrap = loSevenSum[7] ^ fullSum[8];
end

endmodule : csfb_alu

// ### tb/csfb_core_asserts.sv
/* Port assertions for csfb_core.
   Assumes a bind from the bench top file. */
`timescale 1ns/10ps
module csfb_core_asserts
    import csfb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire csfb_instr_t instr,
    input wire logic instrValid,
    input wire logic instrReady,
    input wire logic memBank,
    input wire logic memWrValid,
    input wire logic [PC_W-1:0] pcOut,
    input wire logic dummyCycle,
    input wire logic tblReadReq,
    input wire logic [15:0] progData,
    input wire logic [7:0] tblLowData,
    input wire logic tblLowValid,
    input wire logic callReq,
    input wire logic [PC_W-1:0] pushData,
    input wire logic pushValid
);
// ************************************
// Port checks
// ************************************
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (!rstn);
logic jumpTake;
logic [2:0] pcHigh;
logic [7:0] pcLow;
logic [7:0] progLow;
assign jumpTake = instrValid && instrReady && instr.toMem && instr.memAddr == OFF_PCL;
assign pcHigh = pcOut[10:8];
assign pcLow = pcOut[7:0];
assign progLow = progData[7:0];
rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data not zero outside read answer");
bank_upper_a: assert property ($past(regRd) && $past(regAddr) == OFF_BANK
    |-> regRdData[7:1] == 7'h00)
    else $error("bank selector upper bits not zero");
status_top_a: assert property ($past(regRd) && $past(regAddr) == OFF_STATUS
    |-> regRdData[7:6] == 2'h0)
    else $error("status top bits not zero");
direct_bank_a: assert property (!instr.indirect |-> !memBank)
    else $error("direct access not in bank zero");
jump_page_a: assert property (jumpTake |=> pcHigh == $past(pcHigh))
    else $error("jump left the current page");
jump_dummy_a: assert property (jumpTake |=> dummyCycle && !instrReady && !memWrValid)
    else $error("no dummy cycle after jump");
bus_jump_a: assert property (regWr && regAddr == OFF_PCL && !instrValid
    |=> dummyCycle && pcLow == $past(regWrData))
    else $error("bus jump wrong");
push_pc_a: assert property (callReq |=> pushValid && pushData == $past(pcOut))
    else $error("call push wrong");
table_seq_a: assert property (tblReadReq && instrReady && !instrValid
    |=> !instrReady ##1 (tblLowValid && tblLowData == $past(progLow)))
    else $error("table read sequence wrong");
endmodule : csfb_core_asserts

// ### tb/csfb_core_test.sv
/* Self-checking bench for csfb_core.
   Assumes csfb_pkg and the checker compiled first. */
`timescale 1ns/10ps
module csfb_core_test
    import csfb_pkg::*;
;
// ************************************
// Stimulus and checks
// ************************************
typedef struct packed {
    logic [7:0] a;
    csfb_op_t op;
    logic [7:0] b;
    logic [3:0] fin;
    logic [7:0] res;
    logic [3:0] fout;
} csfb_row_t;
logic clk_sys = 1'h0, rstn = 1'h0, regWr = 1'h0, regRd = 1'h0, instrValid = 1'h0;
logic tblReadReq = 1'h0, callReq = 1'h0, haltExec = 1'h0, wdtRefreshExec = 1'h0;
logic wdtTimeout = 1'h0, softReset = 1'h0, softResetWdtIdle = 1'h0;
logic [6:0] regAddr = 7'h00;
logic [7:0] regWrData = 8'h00;
logic [15:0] progData = 16'hBEEF;
csfb_instr_t instr = '0;
logic [7:0] regRdData, memWrData, tblLowData, v;
logic [6:0] memWrAddr;
logic [PC_W-1:0] pcOut, pushData;
logic [15:0] progAddr;
logic instrReady, memBank, memWrValid, dummyCycle, tblLowValid, pushValid, irq;
int failures = 0, checks_done = 0, cycles = 0;
csfb_row_t rows [15];
csfb_core dut_u (.clk_sys, .rstn, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .instr, .instrValid, .instrReady, .memBank, .memWrData, .memWrAddr, .memWrValid,
    .pcOut, .dummyCycle, .tblReadReq, .progAddr, .progData, .tblLowData, .tblLowValid,
    .callReq, .pushData, .pushValid, .haltExec, .wdtRefreshExec, .wdtTimeout,
    .softReset, .softResetWdtIdle, .irq);
always #4 clk_sys = ~clk_sys;
task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask : test_done
always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
        failures++;
        test_done();
    end
end
task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
        failures++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask : chk
task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge clk_sys);
    regWr <= 1'h0;
endtask : wr
task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk_sys);
    regRd <= 1'h0;
    @(negedge clk_sys);
    v = regRdData;
    chk(v, exp);
endtask : rdc
task automatic exe(input csfb_op_t op, input logic [7:0] b, input logic m, input logic [6:0] ad);
    @(posedge clk_sys);
    instr <= '{op, b, m, 1'h0, ad};
    instrValid <= 1'h1;
    @(posedge clk_sys);
    instrValid <= 1'h0;
    @(negedge clk_sys);
endtask : exe
task automatic ev(input logic [5:0] m);
    @(posedge clk_sys);
    {callReq, softResetWdtIdle, softReset, wdtRefreshExec, haltExec, wdtTimeout} <= m;
    @(posedge clk_sys);
    {callReq, softResetWdtIdle, softReset, wdtRefreshExec, haltExec, wdtTimeout} <= 6'h00;
    @(negedge clk_sys);
endtask : ev
initial begin
    rows = '{
        '{8'h7F, OP_ADD, 8'h01, 4'h0, 8'h80, 4'hA}, '{8'hFF, OP_ADD, 8'h01, 4'h0, 8'h00, 4'h7},
        '{8'h05, OP_SUB, 8'h05, 4'h0, 8'h00, 4'h7}, '{8'h00, OP_SUB, 8'h01, 4'hF, 8'hFF, 4'h0},
        '{8'h0F, OP_ADC, 8'h00, 4'h1, 8'h10, 4'h2}, '{8'h80, OP_SBC, 8'h01, 4'h1, 8'h7F, 4'h9},
        '{8'hF0, OP_AND, 8'h0F, 4'hB, 8'h00, 4'hF}, '{8'h12, OP_OR, 8'h01, 4'hF, 8'h13, 4'hB},
        '{8'h55, OP_XOR, 8'h55, 4'h0, 8'h00, 4'h4}, '{8'hFF, OP_CPL, 8'hFF, 4'h0, 8'h00, 4'h4},
        '{8'hFF, OP_INC, 8'hFF, 4'hB, 8'h00, 4'hF}, '{8'h01, OP_DEC, 8'h01, 4'h0, 8'h00, 4'h4},
        '{8'h00, OP_RLC, 8'h80, 4'h0, 8'h00, 4'h1}, '{8'h00, OP_RRC, 8'h02, 4'h7, 8'h81, 4'h6},
        '{8'h33, OP_MOVA, 8'h5A, 4'hF, 8'h5A, 4'hF}};
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    rdc(OFF_BANK, 8'h00);
    for (int i = 0; i < 15; i++) begin
        wr(OFF_STATUS, {4'h0, rows[i].fin});
        wr(OFF_ACC, rows[i].a);
        exe(rows[i].op, rows[i].b, 1'h0, 7'h00);
        rdc(OFF_ACC, rows[i].res);
        rdc(OFF_STATUS, {4'h0, rows[i].fout});
    end
    wr(OFF_BANK, 8'hFF);
    rdc(OFF_BANK, 8'h01);
    ev(6'h18);
    rdc(OFF_BANK, 8'h01);
    ev(6'h08);
    rdc(OFF_BANK, 8'h00);
    wr(OFF_EVT_CLR, 8'h0F);
    wr(OFF_EVT_EN, 8'h01);
    ev(6'h01);
    chk(irq, 1'h1);
    wr(OFF_STATUS, 8'hFF);
    rdc(OFF_STATUS, 8'h2F);
    wr(OFF_EVT_CLR, 8'h01);
    ev(6'h02);
    chk(irq, 1'h0);
    rdc(OFF_STATUS, 8'h1F);
    rdc(OFF_EVT_STAT, 8'h02);
    ev(6'h04);
    rdc(OFF_STATUS, 8'h0F);
    wr(OFF_PCL, 8'hFF);
    exe(OP_NONE, 8'h00, 1'h0, 7'h00);
    wr(OFF_ACC, 8'h00);
    exe(OP_ADD, 8'h40, 1'h1, OFF_PCL);
    chk({pcOut, dummyCycle, instrReady, memWrValid}, {11'h140, 3'h4});
    wr(OFF_PCL, 8'h90);
    @(negedge clk_sys);
    chk({pcOut, dummyCycle}, {11'h190, 1'h1});
    wr(OFF_BANK, 8'h01);
    wr(OFF_ACC, 8'h21);
    exe(OP_ADD, 8'h10, 1'h1, 7'h20);
    chk({memBank, memWrValid, memWrAddr, memWrData}, {2'h1, 7'h20, 8'h31});
    @(posedge clk_sys);
    instr.indirect <= 1'h1;
    @(negedge clk_sys);
    chk(memBank, 1'h1);
    wr(OFF_TABLE_POINTER_LOW, 8'h34);
    wr(OFF_TABLE_POINTER_HIGH, 8'h12);
    @(posedge clk_sys);
    tblReadReq <= 1'h1;
    @(posedge clk_sys);
    tblReadReq <= 1'h0;
    repeat (4) if (tblLowValid !== 1'h1) @(negedge clk_sys);
    chk({tblLowValid, tblLowData}, {1'h1, 8'hEF});
    chk(progAddr, 16'h1234);
    rdc(OFF_TABLE_RESULT_HIGH, 8'hBE);
    ev(6'h20);
    chk({pushValid, pushData}, {1'h1, 11'h191});
    wr(7'h30, 8'hFF);
    rdc(7'h30, 8'h00);
    ev(6'h03);
    rdc(OFF_STATUS, 8'h30);
    @(posedge clk_sys);
    rstn <= 1'h0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    rdc(OFF_BANK, 8'h00);
    rdc(OFF_EVT_EN, 8'h00);
    wr(OFF_STATUS, 8'h0F);
    rdc(OFF_STATUS, 8'h0F);
    chk(v[7:4], 4'h0);
    test_done();
end
endmodule : csfb_core_test
bind csfb_core csfb_core_asserts chk_u (.clk_sys, .rstn, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .instr, .instrValid, .instrReady, .memBank, .memWrValid, .pcOut, .dummyCycle,
    .tblReadReq, .progData, .tblLowData, .tblLowValid, .callReq, .pushData, .pushValid);
